// ===== logic/printer_port_spp_registers.sv
// host-visible register set of a legacy printer parallel port with a small epp engine
// assumes host i/o strobes and printer pins are synchronous to clk
//
// Behaviour
// - write to offset 0 latches data byte; latch drives data pins uninverted
// - data latch clears on reset
// - data offset read returns live data pin levels, not the latch
// - status value captured at read start and held through the read
// - status bit 0 sets on a 10 us epp timeout; reset clears it
// - clear-mode 0: writing 1 to status bit 0 clears timeout flag
// - clear-mode 1: end of status read clears timeout flag
// - status bits 1 and 2 always read zero
// - status bit 3 reflects fault input level
// - status bit 4 reflects online-select input level
// - status bit 5 reflects media-empty input level
// - status bit 6 reflects acknowledge input level
// - status bit 7 is inverted busy input level
// - control bits 0-5 reset; bits 6 and 7 read zero
// - control bit 0 drives strobe pin inverted
// - control bit 1 drives line-feed pin inverted
// - offsets 3-7 answer only in epp mode; 0-2 in every mode
// - data and control read/write; status writable only in epp mode
// - control bit 2 drives printer reset pin uninverted
// - control bit 3 drives select-request pin inverted
// - with bit 4 set, acknowledge rising edge raises interrupt request
// - control bit 5 sets data direction except printer mode always drives
`timescale 1ns/1ps
`include "printer_port_cfg.svh"

module printer_port_spp_registers
	import printer_port_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = `PP_TIMEOUT_CYC
)(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// configuration levels
	input  wire logic [15:0] port_base,
	input  wire logic [1:0]  port_mode,
	input  wire logic        timeout_clear_mode,
	// host i/o access
	input  wire logic [15:0] host_addr,
	input  wire logic [7:0]  host_wdata,
	input  wire logic        host_write,
	input  wire logic        host_read,
	output logic             host_ready,
	output logic [7:0]       host_rdata,
	output logic             host_rdata_valid,
	// printer data pins
	input  wire logic [7:0]  printer_data_pins_in,
	output logic [7:0]       printer_data_pins_out,
	output logic             printer_data_pins_oe,
	// printer handshake inputs
	input  wire logic        fault_pin_n,
	input  wire logic        online_status_in,
	input  wire logic        media_empty_in,
	input  wire logic        peripheral_acknowledge_in,
	input  wire logic        peripheral_busy_in,
	// printer control outputs
	output logic             data_pulse_pin_n,
	output logic             line_feed_pin_n,
	output logic             printer_reset_ctl,
	output logic             select_request_pin_n,
	// interrupt request
	output logic             ack_irq
);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	wire [15:0] addr_delta = host_addr - port_base;
	wire        in_window  = (addr_delta < `PP_WINDOW_WORDS);
	wire [2:0]  offset     = addr_delta[2:0];
	wire        epp_mode   = (port_mode_t'(port_mode) == MODE_EPP);

	function automatic logic offset_live(input logic [2:0] ofs, input logic epp);
		offset_live = (ofs < `PP_OFS_EPP_ADDR) || epp;
	endfunction : offset_live

	wire hit        = in_window && offset_live(offset, epp_mode);
	wire is_data    = hit && (offset == `PP_OFS_DATA);
	wire is_status  = hit && (offset == `PP_OFS_STATUS);
	wire is_control = hit && (offset == `PP_OFS_CONTROL);
	wire is_epp     = hit && (offset >= `PP_OFS_EPP_ADDR);
	wire is_epp_adr = hit && (offset == `PP_OFS_EPP_ADDR);

	// ----------------------------------------
	// handshake synchronisers
	// ----------------------------------------
	localparam int NSYNC = 5;
	wire  [NSYNC-1:0] raw_in = {peripheral_busy_in, peripheral_acknowledge_in,
		media_empty_in, online_status_in, fault_pin_n};
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++)
		begin : g_sync
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end
				else
				begin
					sync1_reg[gi] <= raw_in[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	wire fault_s  = sync2_reg[0];
	wire online_s = sync2_reg[1];
	wire media_s  = sync2_reg[2];
	wire ack_s    = sync2_reg[3];
	wire busy_s   = sync2_reg[4];

	// ----------------------------------------
	// host strobes
	// ----------------------------------------
	logic host_read_d_reg;
	logic read_was_status_reg;
	wire  read_start = host_read && !host_read_d_reg;
	wire  read_end   = !host_read && host_read_d_reg;
	wire  buf_in_ready;
	assign host_ready = is_epp ? buf_in_ready : 1'b1;
	wire  wr_take    = host_write && host_ready;

	// ----------------------------------------
	// data latch and control register
	// ----------------------------------------
	logic [7:0] data_latch_reg;
	logic [5:0] ctrl_reg;
	wire  [7:0] ctrl_view = {2'b00, ctrl_reg};

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			data_latch_reg <= `PP_DATA_RESET;
			ctrl_reg       <= `PP_CTRL_RESET;
		end
		else
		begin
			if (wr_take && is_data)
				data_latch_reg <= host_wdata;
			if (wr_take && is_control)
				ctrl_reg <= host_wdata[5:0];
		end
	end

	// ----------------------------------------
	// timeout flag
	// ----------------------------------------
	logic tmo_flag_reg;
	logic epp_timeout;
	wire  tmo_wclr = wr_take && is_status && epp_mode && !timeout_clear_mode
		&& host_wdata[`PP_ST_TIMEOUT];
	wire  tmo_rclr = read_end && read_was_status_reg && timeout_clear_mode;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			tmo_flag_reg <= 1'b0;
		else if (epp_timeout)
			tmo_flag_reg <= 1'b1;
		else if (tmo_wclr || tmo_rclr)
			tmo_flag_reg <= 1'b0;
	end

	// ----------------------------------------
	// status view
	// ----------------------------------------
	wire [7:0] status_view;
	assign status_view[`PP_ST_TIMEOUT] = tmo_flag_reg;
	assign status_view[2:1]            = 2'b00;
	assign status_view[`PP_ST_FAULT]   = fault_s;
	assign status_view[`PP_ST_ONLINE]  = online_s;
	assign status_view[`PP_ST_MEDIA]   = media_s;
	assign status_view[`PP_ST_ACK]     = ack_s;
	assign status_view[`PP_ST_READY]   = ~busy_s;

	// ----------------------------------------
	// epp request queue
	// ----------------------------------------
	// entry: {read, address cycle, byte}; a stalled engine back-pressures writes
	logic       rd_req_reg;
	logic       rd_req_adr_reg;
	wire        q_wr    = wr_take && is_epp;
	wire        q_rd    = rd_req_reg && !q_wr;
	wire        q_valid = q_wr || q_rd;
	wire [9:0]  q_in    = q_wr ? {1'b0, is_epp_adr, host_wdata}
		: {1'b1, rd_req_adr_reg, `PP_EPP_RESET};
	wire        q_out_valid;
	wire [9:0]  q_out;
	epp_state_t state_reg;
	wire        q_pop   = (state_reg == EPP_IDLE);

	epp_request_buffer #(
		.WIDTH (10)
	) u_queue (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (q_valid),
		.in_ready  (buf_in_ready),
		.in_data   (q_in),
		.out_valid (q_out_valid),
		.out_ready (q_pop),
		.out_data  (q_out)
	);

	// ----------------------------------------
	// epp cycle engine
	// ----------------------------------------
	// the peripheral's wait line shares the busy pin; low lets a cycle strobe, high ends it
	epp_state_t state_next;
	logic [9:0] cur_reg;
	logic [15:0] tmo_cnt_reg;
	logic [7:0] epp_rdata_reg;
	logic       epp_rd_done_reg;
	wire        cur_read  = cur_reg[9];
	wire        cur_addr  = cur_reg[8];
	wire        tmo_hit   = (tmo_cnt_reg == 16'(TIMEOUT_CYCLES - 1));
	wire        finish_ok = (state_reg == EPP_STROBE) && busy_s;
	assign epp_timeout = (state_reg != EPP_IDLE) && tmo_hit && !finish_ok;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			EPP_IDLE:
				if (q_out_valid)
					state_next = EPP_WAIT_LOW;
			EPP_WAIT_LOW:
				if (epp_timeout)
					state_next = EPP_IDLE;
				else if (!busy_s)
					state_next = EPP_STROBE;
			EPP_STROBE:
				if (finish_ok || epp_timeout)
					state_next = EPP_IDLE;
			default:
				state_next = EPP_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg       <= EPP_IDLE;
			cur_reg         <= '0;
			tmo_cnt_reg     <= '0;
			epp_rdata_reg   <= `PP_EPP_RESET;
			epp_rd_done_reg <= 1'b0;
		end
		else
		begin
			state_reg       <= state_next;
			epp_rd_done_reg <= 1'b0;
			if (state_reg == EPP_IDLE)
				tmo_cnt_reg <= '0;
			else
				tmo_cnt_reg <= tmo_cnt_reg + 16'd1;
			if (q_pop && q_out_valid)
				cur_reg <= q_out;
			if (cur_read && finish_ok)
				epp_rdata_reg <= printer_data_pins_in;
			else if (cur_read && epp_timeout)
				epp_rdata_reg <= `PP_RD_TIMEOUT;
			if (cur_read && (finish_ok || epp_timeout))
				epp_rd_done_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// host read path
	// ----------------------------------------
	wire [7:0] plain_rdata = is_data    ? printer_data_pins_in
		: is_status  ? status_view
		: is_control ? ctrl_view
		: 8'h00;
	logic rd_wait_reg;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			host_read_d_reg     <= 1'b0;
			read_was_status_reg <= 1'b0;
			rd_req_reg          <= 1'b0;
			rd_req_adr_reg      <= 1'b0;
			rd_wait_reg         <= 1'b0;
			host_rdata          <= 8'h00;
			host_rdata_valid    <= 1'b0;
		end
		else
		begin
			host_read_d_reg <= host_read;
			if (read_start)
				read_was_status_reg <= is_status;
			if (q_rd && buf_in_ready)
				rd_req_reg <= 1'b0;
			if (read_start && is_epp)
			begin
				rd_req_reg     <= 1'b1;
				rd_req_adr_reg <= is_epp_adr;
				rd_wait_reg    <= 1'b1;
			end
			else if (read_start)
			begin
				// value frozen here so a changing pin cannot tear the read
				host_rdata       <= plain_rdata;
				host_rdata_valid <= 1'b1;
			end
			else if (rd_wait_reg && epp_rd_done_reg)
			begin
				host_rdata       <= epp_rdata_reg;
				host_rdata_valid <= 1'b1;
				rd_wait_reg      <= 1'b0;
			end
			else if (!host_read)
			begin
				host_rdata_valid <= 1'b0;
				rd_wait_reg      <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	wire epp_busy   = (state_reg != EPP_IDLE);
	wire epp_strobe = (state_reg == EPP_STROBE);
	wire drive_dir  = (port_mode_t'(port_mode) == MODE_PRINTER)
		|| !ctrl_reg[`PP_CT_DIR];
	wire oe_next    = epp_busy ? !cur_read : drive_dir;
	wire [7:0] pins_next = (epp_busy && !cur_read) ? cur_reg[7:0] : data_latch_reg;
	logic ack_d_reg;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			printer_data_pins_out <= `PP_DATA_RESET;
			printer_data_pins_oe  <= 1'b1;
			data_pulse_pin_n      <= 1'b1;
			line_feed_pin_n       <= 1'b1;
			printer_reset_ctl     <= 1'b0;
			select_request_pin_n  <= 1'b1;
			ack_d_reg             <= 1'b0;
			ack_irq               <= 1'b0;
		end
		else
		begin
			printer_data_pins_out <= pins_next;
			printer_data_pins_oe  <= oe_next;
			// strobe bit overrides the epp write line, as on the real port
			data_pulse_pin_n <= epp_busy ? (cur_read && !ctrl_reg[`PP_CT_STROBE])
				: ~ctrl_reg[`PP_CT_STROBE];
			line_feed_pin_n <= (epp_strobe && !cur_addr) ? 1'b0
				: ~ctrl_reg[`PP_CT_LINE_FEED];
			printer_reset_ctl <= ctrl_reg[`PP_CT_RESET];
			select_request_pin_n <= (epp_strobe && cur_addr) ? 1'b0
				: ~ctrl_reg[`PP_CT_SELECT];
			ack_d_reg <= ack_s;
			ack_irq   <= ctrl_reg[`PP_CT_IRQ_EN] && ack_s && !ack_d_reg;
		end
	end

endmodule : printer_port_spp_registers

// ===== include/printer_port_cfg.svh
// constants of the printer port register block: offsets, field positions, resets, timing
// assumes an 8-bit host i/o data path and the 100 MHz system clock
`ifndef PRINTER_PORT_CFG_SVH
`define PRINTER_PORT_CFG_SVH

// ----------------------------------------
// register offsets from the port base
// ----------------------------------------
`define PP_OFS_DATA      3'h0
`define PP_OFS_STATUS    3'h1
`define PP_OFS_CONTROL   3'h2
`define PP_OFS_EPP_ADDR  3'h3
`define PP_OFS_EPP_DATA0 3'h4
`define PP_WINDOW_WORDS  16'h0008

// ----------------------------------------
// status field positions
// ----------------------------------------
`define PP_ST_TIMEOUT    0
`define PP_ST_FAULT      3
`define PP_ST_ONLINE     4
`define PP_ST_MEDIA      5
`define PP_ST_ACK        6
`define PP_ST_READY      7

// ----------------------------------------
// control field positions
// ----------------------------------------
`define PP_CT_STROBE     0
`define PP_CT_LINE_FEED  1
`define PP_CT_RESET      2
`define PP_CT_SELECT     3
`define PP_CT_IRQ_EN     4
`define PP_CT_DIR        5

// ----------------------------------------
// reset values and the timed-out read byte
// ----------------------------------------
`define PP_DATA_RESET    8'h00
`define PP_CTRL_RESET    6'h00
`define PP_EPP_RESET     8'h00
`define PP_RD_TIMEOUT    8'hFF

// ----------------------------------------
// timing
// ----------------------------------------
`define PP_CLK_PERIOD_NS 10
`define PP_TIMEOUT_NS    10000
`define PP_TIMEOUT_CYC   (`PP_TIMEOUT_NS / `PP_CLK_PERIOD_NS)

`endif

// ===== include/printer_port_pkg.sv
// types shared by the printer port register block
// assumes printer_port_cfg.svh supplies the numeric constants
package printer_port_pkg;

	// ----------------------------------------
	// port operating modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_PRINTER = 2'b00,
		MODE_BIDIR   = 2'b01,
		MODE_EPP     = 2'b10,
		MODE_ECP     = 2'b11
	} port_mode_t;

	// ----------------------------------------
	// epp cycle engine states
	// ----------------------------------------
	typedef enum logic [1:0] {
		EPP_IDLE     = 2'b00,
		EPP_WAIT_LOW = 2'b01,
		EPP_STROBE   = 2'b10
	} epp_state_t;

endpackage : printer_port_pkg

// ===== logic/epp_request_buffer.sv
// two-entry valid/ready buffer for queued epp cycle requests
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps

module epp_request_buffer
	import printer_port_pkg::*;
#(
	parameter int WIDTH = 10
)(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	logic [WIDTH-1:0] slot_reg [2];
	logic             rd_ptr_reg;
	logic             wr_ptr_reg;
	logic [1:0]       count_reg;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = (count_reg != 2'd2);
	assign out_valid = (count_reg != 2'd0);
	assign out_data  = slot_reg[rd_ptr_reg];

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rd_ptr_reg <= 1'b0;
			wr_ptr_reg <= 1'b0;
			count_reg  <= 2'd0;
			slot_reg[0] <= '0;
			slot_reg[1] <= '0;
		end
		else
		begin
			if (push)
			begin
				slot_reg[wr_ptr_reg] <= in_data;
				wr_ptr_reg           <= ~wr_ptr_reg;
			end
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule : epp_request_buffer

// ===== sim/printer_port_spp_registers_monitor.sv
// concurrent checks on the ports of the printer port register block
// assumes one clk domain and reset_n asynchronous, active low
`timescale 1ns/1ps

module printer_port_spp_registers_monitor
	import printer_port_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// host side
	input wire logic [15:0] port_base,
	input wire logic [1:0]  port_mode,
	input wire logic [15:0] host_addr,
	input wire logic [7:0]  host_wdata,
	input wire logic        host_write,
	input wire logic        host_ready,
	input wire logic        host_read,
	input wire logic [7:0]  host_rdata,
	input wire logic        host_rdata_valid,
	// printer side
	input wire logic [7:0]  printer_data_pins_in,
	input wire logic [7:0]  printer_data_pins_out,
	input wire logic        printer_data_pins_oe,
	input wire logic        data_pulse_pin_n,
	input wire logic        line_feed_pin_n,
	input wire logic        printer_reset_ctl,
	input wire logic        select_request_pin_n
);
	logic [15:0] offset;
	logic        spp_write;
	// epp cycles own the pins, so pin checks stay outside epp mode
	assign offset    = host_addr - port_base;
	assign spp_write = host_write && host_ready && port_mode != MODE_EPP;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_data_latch_drive: assert property (spp_write && offset == 16'h0000
		|-> ##2 printer_data_pins_out == $past(host_wdata, 2)) else $error("data pins miss write");
	a_control_pin_levels: assert property (spp_write && offset == 16'h0002
		|-> ##2 ({select_request_pin_n, printer_reset_ctl, line_feed_pin_n, data_pulse_pin_n}
		^ 4'b1011) == $past(host_wdata[3:0], 2)) else $error("control pins wrong");
	a_status_zero_bits: assert property ($rose(host_read) && offset == 16'h0001
		|=> host_rdata_valid && host_rdata[2:1] == 2'b00) else $error("status bits 1-2 set");
	a_window_decode: assert property ($rose(host_read) && (offset >= 16'h0008
		|| (offset >= 16'h0003 && port_mode != MODE_EPP))
		|=> host_rdata_valid && host_rdata == 8'h00) else $error("silent offset answered");
	a_data_read_live: assert property ($rose(host_read) && offset == 16'h0000
		|=> host_rdata == $past(printer_data_pins_in)) else $error("data read not live");
	a_read_held: assert property (host_rdata_valid |=> $stable(host_rdata))
		else $error("read data moved");
	a_valid_release: assert property ($fell(host_read) |=> !host_rdata_valid)
		else $error("valid outlived read");
	a_printer_drives: assert property (port_mode == MODE_PRINTER
		&& $past(port_mode) == MODE_PRINTER |-> printer_data_pins_oe) else $error("pins released");
endmodule : printer_port_spp_registers_monitor

bind printer_port_spp_registers printer_port_spp_registers_monitor u_monitor (
	.clk(clk), .reset_n(reset_n), .port_base(port_base), .port_mode(port_mode),
	.host_addr(host_addr), .host_wdata(host_wdata), .host_write(host_write),
	.host_ready(host_ready), .host_read(host_read), .host_rdata(host_rdata),
	.host_rdata_valid(host_rdata_valid), .printer_data_pins_in(printer_data_pins_in),
	.printer_data_pins_out(printer_data_pins_out), .printer_data_pins_oe(printer_data_pins_oe),
	.data_pulse_pin_n(data_pulse_pin_n), .line_feed_pin_n(line_feed_pin_n),
	.printer_reset_ctl(printer_reset_ctl), .select_request_pin_n(select_request_pin_n)
);

// ===== sim/printer_cable_peer.sv
// printer-side model on the cable of the printer port register block
// assumes clk shared with the block; busy doubles as the epp wait line
`timescale 1ns/1ps

module printer_cable_peer
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// bench controls
	input  wire logic       epp_on,
	input  wire logic       stall,
	input  wire logic [7:0] drive_byte,
	input  wire logic [4:0] status_lvl,
	output logic [7:0]      got_byte,
	// cable
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	input  wire logic       data_pulse_pin_n,
	input  wire logic       line_feed_pin_n,
	input  wire logic       select_request_pin_n,
	output logic [7:0]      data_in,
	output logic            fault_pin_n,
	output logic            online_status_in,
	output logic            media_empty_in,
	output logic            peripheral_acknowledge_in,
	output logic            peripheral_busy_in
);
	logic strobe_seen;
	logic wait_reg;
	// peer drives the bus whenever the port has turned it round
	assign data_in     = data_oe ? data_out : drive_byte;
	assign strobe_seen = epp_on && (!line_feed_pin_n || !select_request_pin_n);
	assign {peripheral_busy_in, peripheral_acknowledge_in, media_empty_in, online_status_in,
		fault_pin_n} = epp_on ? {wait_reg, status_lvl[3:0]} : status_lvl;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wait_reg <= 1'b0;
			got_byte <= 8'h00;
		end
		else
		begin
			// a stalled peer never lifts wait, so the cycle runs into the timeout
			wait_reg <= strobe_seen && !stall;
			if (strobe_seen && !data_pulse_pin_n)
				got_byte <= data_out;
		end
	end
endmodule : printer_cable_peer

// ===== sim/printer_port_spp_registers_tb.sv
// self-checking bench of the printer port register block with a cable peer
// assumes the package, the design, the peer and the monitor are compiled first
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			fails++; \
			$display("wrong value at %0t: got %h expected %h", $time, got, exp); \
		end \
	end

module printer_port_spp_registers_tb import printer_port_pkg::*;;
	localparam logic [15:0] BASE = 16'h0240;
	logic clk = 1'b0, reset_n = 1'b0, host_write = 1'b0, host_read = 1'b0;
	logic clear_mode = 1'b0, epp_on = 1'b0, stall = 1'b0;
	logic [1:0] port_mode = MODE_PRINTER;
	logic [15:0] host_addr = 16'h0000, port_base = BASE;
	logic [7:0] host_wdata = 8'h00, drive_byte = 8'h3C, rd_byte;
	logic [4:0] status_lvl = 5'b00011;
	logic host_ready, host_rdata_valid, pins_oe, fault_n, online, media, ack, busy, irq;
	logic strobe_n, feed_n, init_ctl, select_n;
	logic [7:0] host_rdata, pins_in, pins_out, got_byte;
	int fails = 0, samples_checked = 0;

	always #5 clk = ~clk;

	printer_port_spp_registers #(.TIMEOUT_CYCLES(20)) u_printer_port_spp_registers (
		.clk(clk), .reset_n(reset_n), .port_base(port_base), .port_mode(port_mode),
		.timeout_clear_mode(clear_mode), .host_addr(host_addr), .host_wdata(host_wdata),
		.host_write(host_write), .host_read(host_read), .host_ready(host_ready),
		.host_rdata(host_rdata), .host_rdata_valid(host_rdata_valid),
		.printer_data_pins_in(pins_in), .printer_data_pins_out(pins_out),
		.printer_data_pins_oe(pins_oe), .fault_pin_n(fault_n), .online_status_in(online),
		.media_empty_in(media), .peripheral_acknowledge_in(ack), .peripheral_busy_in(busy),
		.data_pulse_pin_n(strobe_n), .line_feed_pin_n(feed_n), .printer_reset_ctl(init_ctl),
		.select_request_pin_n(select_n), .ack_irq(irq));
	printer_cable_peer u_printer_cable_peer (
		.clk(clk), .reset_n(reset_n), .epp_on(epp_on), .stall(stall), .drive_byte(drive_byte),
		.status_lvl(status_lvl), .got_byte(got_byte), .data_out(pins_out), .data_oe(pins_oe),
		.data_pulse_pin_n(strobe_n), .line_feed_pin_n(feed_n), .select_request_pin_n(select_n),
		.data_in(pins_in), .fault_pin_n(fault_n), .online_status_in(online),
		.media_empty_in(media), .peripheral_acknowledge_in(ack), .peripheral_busy_in(busy));

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		int n = 0;
		@(posedge clk);
		host_addr <= a;
		host_wdata <= d;
		host_write <= 1'b1;
		@(negedge clk);
		while (host_ready !== 1'b1 && n++ < 2000)
			@(negedge clk);
		if (n > 2000)
		begin
			fails++;
			$display("wrong value at %0t: write never taken", $time);
		end
		@(posedge clk);
		host_write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		int n = 0;
		@(posedge clk);
		host_addr <= a;
		host_read <= 1'b1;
		@(negedge clk);
		while (host_rdata_valid !== 1'b1 && n++ < 2000)
			@(negedge clk);
		d = host_rdata;
		@(posedge clk);
		host_read <= 1'b0;
		while (host_rdata_valid !== 1'b0 && n++ < 2100)
			@(negedge clk);
		if (n > 2000 || host_rdata_valid !== 1'b0)
		begin
			fails++;
			$display("wrong value at %0t: read handshake stuck", $time);
		end
	endtask : rd

	task automatic t_regs;
		logic [4:0] pat [2] = '{5'b10101, 5'b01010};
		`CHK({strobe_n, feed_n, init_ctl, select_n, pins_out}, 12'hD00)
		wr(BASE, 8'hA5);
		wr(BASE, 8'h5A);
		tick(3);
		`CHK(pins_out, 8'h5A)
		for (int i = 0; i < 4; i++)
		begin
			wr(BASE + 16'h0002, 8'h01 << i);
			tick(3);
			`CHK({select_n, init_ctl, feed_n, strobe_n}, 4'b1011 ^ (4'h1 << i))
		end
		wr(BASE + 16'h0002, 8'hFF);
		rd(BASE + 16'h0002, rd_byte);
		`CHK({rd_byte, pins_oe}, 9'h07F)
		@(posedge clk);
		port_mode <= MODE_BIDIR;
		rd(BASE, rd_byte);
		`CHK({rd_byte, pins_oe}, 9'h078)
		wr(BASE + 16'h0002, 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk);
			status_lvl <= pat[i];
			tick(4);
			rd(BASE + 16'h0001, rd_byte);
			`CHK(rd_byte, {~pat[i][4], pat[i][3:0], 3'b000})
		end
		rd(BASE + 16'h0008, rd_byte);
		`CHK(rd_byte, 8'h00)
		rd(BASE - 16'h0001, rd_byte);
		`CHK(rd_byte, 8'h00)
		rd(BASE + 16'h0003, rd_byte);
		`CHK(rd_byte, 8'h00)
		wr(BASE + 16'h0008, 8'hFF);
		wr(BASE + 16'h0004, 8'hFF);
		tick(3);
		`CHK(pins_out, 8'h5A)
		// moved base: only the new window may reach the latch
		@(posedge clk);
		port_base <= BASE + 16'h0100;
		wr(BASE + 16'h0100, 8'hC3);
		wr(BASE, 8'h00);
		tick(3);
		`CHK(pins_out, 8'hC3)
		@(posedge clk);
		port_base <= BASE;
		$display("test registers done");
	endtask : t_regs

	task automatic t_epp;
		@(posedge clk);
		port_mode <= MODE_EPP;
		epp_on <= 1'b1;
		wr(BASE + 16'h0003, 8'h99);
		tick(10);
		`CHK(got_byte, 8'h99)
		rd(BASE + 16'h0004, rd_byte);
		`CHK(rd_byte, 8'h3C)
		stall <= 1'b1;
		for (int i = 1; i < 4; i++)
			wr(BASE + 16'h0004, 8'h11 * i[7:0]);
		tick(1);
		`CHK(host_ready, 1'b0)
		wr(BASE + 16'h0004, 8'h44);
		stall <= 1'b0;
		tick(40);
		`CHK({host_ready, got_byte}, 9'h144)
		@(posedge clk);
		port_mode <= MODE_PRINTER;
		wr(BASE + 16'h0001, 8'h01);
		@(posedge clk);
		port_mode <= MODE_EPP;
		for (int i = 0; i < 3; i++)
		begin
			rd(BASE + 16'h0001, rd_byte);
			`CHK(rd_byte[0], i < 2)
			wr(BASE + 16'h0001, i[7:0]);
		end
		@(posedge clk);
		clear_mode <= 1'b1;
		stall <= 1'b1;
		wr(BASE + 16'h0004, 8'h77);
		tick(30);
		for (int i = 0; i < 2; i++)
		begin
			rd(BASE + 16'h0001, rd_byte);
			`CHK(rd_byte[0], i == 0)
		end
		stall <= 1'b0;
		$display("test epp done");
	endtask : t_epp

	task automatic t_irq;
		logic [3:0] hits;
		@(posedge clk);
		port_mode <= MODE_PRINTER;
		epp_on <= 1'b0;
		for (int k = 0; k < 2; k++)
		begin
			wr(BASE + 16'h0002, k == 0 ? 8'h10 : 8'h00);
			status_lvl[3] <= 1'b0;
			tick(4);
			@(posedge clk);
			status_lvl[3] <= 1'b1;
			hits = 4'h0;
			repeat (8) @(negedge clk) hits += {3'b000, irq};
			`CHK(hits, k == 0 ? 4'h1 : 4'h0)
		end
		$display("test interrupt done");
	endtask : t_irq

	task automatic finish_test;
		$display("checked %0d values, %0d wrong", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	initial
	begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_epp();
		t_irq();
		finish_test();
	end

	// generous against about 300 cycles of tests
	initial
	begin
		#200000;
		fails++;
		finish_test();
	end
endmodule : printer_port_spp_registers_tb
